// ==== hdl/mcr_defines.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the
//          monitor configuration register bank
// Assumes: 100 MHz ref_clk
// Notes:   included by the pacer and register modules of the bank, not by its type package
`ifndef MCR_DEFINES_SVH
`define MCR_DEFINES_SVH

// register offsets on the serial register port
`define MCR_OFS_FAN_PIN     8'h05
`define MCR_OFS_OS_RES      8'h06
`define MCR_OFS_PACE        8'h07
`define MCR_OFS_CHAN_DIS    8'h08

// reset values
`define MCR_RST_FAN_PIN     8'h14
`define MCR_RST_OS_CTL      3'h0
`define MCR_RST_PACE        8'h40
`define MCR_RST_CHAN_DIS    8'h00
`define MCR_RST_PIN_LEVEL   1'b1

// fan and shared pin fields
`define MCR_FIRST_TACH_INPUT_LEVEL_BIT  0
`define MCR_SECOND_TACH_INPUT_LEVEL_BIT  1
`define MCR_FIRST_TACH_INPUT_FIELD_LO   2
`define MCR_SECOND_TACH_INPUT_FIELD_LO   4
`define MCR_OS_EN_BIT       6
`define MCR_RSTOUT_EN_BIT   7
`define MCR_FIELD_ACT_LOW   2'h1

// overtemp and resolution fields
`define MCR_OS_STATUS_BIT   0
`define MCR_OS_POL_BIT      1
`define MCR_OS_ONESHOT_BIT  2
`define MCR_TEMP_RES_BIT    3
`define MCR_TEMP_LOW_LO     4

// pacing and channel fields
`define MCR_CONT_BIT        0
`define MCR_TEMP_CHAN       7

// timing
`define MCR_CLK_MHZ         100
`define MCR_PACE_UNIT_US    1420
`define MCR_PACE_UNIT_CYC   (`MCR_PACE_UNIT_US * `MCR_CLK_MHZ)
`define MCR_PACE_OFFSET     11'd6
`define MCR_RST_PULSE_US    20
`define MCR_RST_PULSE_CYC   (`MCR_RST_PULSE_US * `MCR_CLK_MHZ)

`endif

// ==== hdl/mcr_pkg.sv ====
// Purpose: types shared by the monitor configuration register bank
// Assumes: nothing
// Notes:   constants live in mcr_defines.svh
package mcr_pkg;

    typedef enum logic [1:0] {
        MCR_PIN_OFF,
        MCR_PIN_OVERTEMP,
        MCR_PIN_RESET
    } mcr_pin_mode_t;

    typedef enum logic [1:0] {
        MCR_PACE_KICK,
        MCR_PACE_BUSY,
        MCR_PACE_DELAY
    } mcr_pace_state_t;

endpackage

// ==== hdl/mcr_pacer.sv ====
// Purpose: paces monitoring cycles, either back to back or with a programmed gap
// Assumes: cycle_done is a one-cycle pulse from the conversion sequencer
// Notes:   the gap count is captured when the gap starts, later writes wait
`include "mcr_defines.svh"

module mcr_pacer import mcr_pkg::*; #(
    parameter int UNIT_CYC = `MCR_PACE_UNIT_CYC
) (
    input  wire logic       ref_clk,      // system clock
    input  wire logic       rst,          // async reset, active high
    input  wire logic       continuous,   // back-to-back monitoring selected
    input  wire logic [7:0] rate_count,   // gap count N
    input  wire logic       cycle_done,   // sequencer finished a cycle
    output logic            cycle_start   // one-cycle pulse: begin a cycle
);

    mcr_pace_state_t state_r;
    logic [31:0]     unit_cnt_r;
    logic [10:0]     units_left_r;
    logic [10:0]     units_total_r;
    logic            start_r;
    logic [31:0]     dly_cnt_r;

    assign cycle_start = start_r;

    // gap of (8N+6) units counted as units of UNIT_CYC, avoiding a wide multiply
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r       <= MCR_PACE_KICK;
            unit_cnt_r    <= 32'h0;
            units_left_r  <= 11'h0;
            units_total_r <= 11'h0;
            start_r       <= 1'b0;
        end else begin
            start_r <= 1'b0;
            case (state_r)
                MCR_PACE_KICK: begin
                    start_r <= 1'b1;
                    state_r <= MCR_PACE_BUSY;
                end
                MCR_PACE_BUSY: begin
                    if (cycle_done) begin
                        if (continuous) begin
                            state_r <= MCR_PACE_KICK;
                        end else begin
                            state_r       <= MCR_PACE_DELAY;
                            unit_cnt_r    <= 32'h0;
                            units_left_r  <= {rate_count, 3'h0} + `MCR_PACE_OFFSET;
                            units_total_r <= {rate_count, 3'h0} + `MCR_PACE_OFFSET;
                        end
                    end
                end
                MCR_PACE_DELAY: begin
                    if (continuous) begin
                        state_r <= MCR_PACE_KICK;
                    end else if (unit_cnt_r == 32'(UNIT_CYC - 1)) begin
                        unit_cnt_r <= 32'h0;
                        if (units_left_r == 11'h1) begin
                            state_r <= MCR_PACE_KICK;
                        end else begin
                            units_left_r <= units_left_r - 11'h1;
                        end
                    end else begin
                        unit_cnt_r <= unit_cnt_r + 32'h1;
                    end
                end
                default: begin
                    state_r <= MCR_PACE_KICK;
                end
            endcase
        end
    end

    // helper: length of the current gap, for the checks only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dly_cnt_r <= 32'h0;
        end else begin
            dly_cnt_r <= (state_r == MCR_PACE_DELAY) ? dly_cnt_r + 32'h1 : 32'h0;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_pace_gap_len: assert property (
        (state_r == MCR_PACE_KICK && $past(state_r) == MCR_PACE_DELAY && !$past(continuous))
        |-> dly_cnt_r == 32'(units_total_r) * 32'(UNIT_CYC))
        else $error("monitoring gap length differs from (8N+6) units");

    a_pace_back2back: assert property (
        (state_r == MCR_PACE_BUSY && cycle_done && continuous) |-> ##2 cycle_start)
        else $error("continuous mode did not start the next cycle at once");

    a_pace_cont_abort: assert property (
        (state_r == MCR_PACE_DELAY && continuous) |=> state_r == MCR_PACE_KICK)
        else $error("continuous mode still waited on the gap count");

endmodule

// ==== hdl/mcr_config_regs.sv ====
// Purpose: fan, shared pin, overtemp, pacing and channel disable configuration
// Assumes: the serial interface engine presents decoded byte accesses on reg_*
// Notes:   shared pin is open drain for reset pulses, push-pull in overtemp use
`include "mcr_defines.svh"

// Summary of operation
// - fan mode bits pick level or counting
// - counting mode field picks divide 1/2/4/8
// - level mode field picks input polarity
// - pin bits 6/7 = 1/0 give overtemp output
// - pin bits 7/6 = 1/0 give reset output
// - both pin bits set disable the pin
// - status bit mirrors pin in overtemp mode
// - polarity bit sets overtemp active level
// - mode bit picks one-shot or comparator
// - resolution bit picks twelve or nine bits
// - high nibble shows low temperature result bits
// - gap of 1.42 ms times (8N+6)
// - continuous bit removes the gap
// - disabled voltage channel skipped, muted, reads zero
// - disabled temperature skipped, muted, reads zero
// - continuous mode ignores the gap count
// - reset request pulses pin low, then clears
module mcr_config_regs import mcr_pkg::*; #(
    parameter int PACE_UNIT_CYC = `MCR_PACE_UNIT_CYC,
    parameter int RST_PULSE_CYC = `MCR_RST_PULSE_CYC
) (
    input  wire logic        ref_clk,              // system clock, 100 MHz
    input  wire logic        rst,                  // async reset, active high
    input  wire logic [7:0]  reg_addr,             // register offset
    input  wire logic [7:0]  reg_wdata,            // write byte
    input  wire logic        reg_wr,               // write strobe
    input  wire logic        reg_rd,               // read strobe
    output logic      [7:0]  reg_rdata,            // read byte, one cycle after reg_rd
    output logic      [1:0]  fan_level_mode,       // per fan: level-sensitive input
    output logic      [1:0]  fan_active_low,       // per fan: level input active low
    output logic      [1:0]  first_tach_input_div_shift,       // first fan divisor as power of two
    output logic      [1:0]  second_tach_input_div_shift,       // second fan divisor as power of two
    input  wire logic        shared_pin_i,         // level seen on the shared pin
    output logic             shared_pin_o,         // level driven on the shared pin
    output logic             shared_pin_oe,        // shared pin driven
    input  wire logic        temp_over_limit,      // temperature beyond its limit
    input  wire logic        os_service,           // overtemp event serviced
    input  wire logic        reset_request,        // reset request bit of main config
    output logic             reset_request_done,   // pulse: clear the reset request
    input  wire logic [3:0]  temp_low_result,      // low result bits, [3] at bit 7
    input  wire logic        cycle_done,           // monitoring cycle finished
    input  wire logic [7:0]  conv_rate_count,      // gap count N
    output logic             cycle_start,          // pulse: begin monitoring cycle
    output logic      [7:0]  chan_skip,            // per channel: skip conversion
    input  wire logic [7:0]  raw_limit_evt,        // limit events, [7] temperature
    output logic      [7:0]  limit_evt,            // limit events after muting
    input  wire logic [2:0]  reading_chan,         // channel of the reading asked for
    input  wire logic [11:0] reading_in,           // stored reading of that channel
    output logic      [11:0] reading_out           // reading as the host sees it
);

    logic [7:0]    fan_cfg_r;
    logic [3:1]    os_ctl_r;
    logic [7:0]    pace_cfg_r;
    logic [7:0]    chan_dis_r;
    logic [7:0]    rdata_r;
    logic [1:0]    level_mode_r;
    logic [1:0]    act_low_r;
    logic [1:0]    div1_r;
    logic [1:0]    div2_r;
    logic [2:0]    pin_sync_r;
    logic          pin_level_r;
    logic          over_q_r;
    logic          os_hit_r;
    logic          os_assert;
    logic          pin_o_r;
    logic          pin_oe_r;
    logic          rst_busy_r;
    logic [31:0]   rst_cnt_r;
    logic          rst_done_r;
    logic [7:0]    limit_evt_r;
    logic [11:0]   reading_r;
    logic          temp_on;
    logic          os_status;
    logic [7:4]    temp_low_view;
    mcr_pin_mode_t pin_mode;
    logic [31:0]   hlp_rst_len;

    function automatic mcr_pin_mode_t pin_mode_of(input logic [7:0] cfg);
        mcr_pin_mode_t m;
        m = MCR_PIN_OFF;
        case ({cfg[`MCR_RSTOUT_EN_BIT], cfg[`MCR_OS_EN_BIT]})
            2'b01:   m = MCR_PIN_OVERTEMP;
            2'b10:   m = MCR_PIN_RESET;
            default: m = MCR_PIN_OFF;
        endcase
        return m;
    endfunction

    // divisor in counting mode, zero when the field means polarity instead
    function automatic logic [1:0] div_of(input logic level, input logic [1:0] field);
        return level ? 2'h0 : field;
    endfunction

    assign pin_mode = pin_mode_of(fan_cfg_r);
    assign temp_on  = ~chan_dis_r[`MCR_TEMP_CHAN];

    // ---------------- register writes ----------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fan_cfg_r <= `MCR_RST_FAN_PIN;
        end else if (reg_wr && reg_addr == `MCR_OFS_FAN_PIN) begin
            fan_cfg_r <= reg_wdata;
        end
    end

    // bit 0 is status and bits 7:4 show the result, so only 3:1 are stored
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            os_ctl_r <= `MCR_RST_OS_CTL;
        end else if (reg_wr && reg_addr == `MCR_OFS_OS_RES) begin
            os_ctl_r <= reg_wdata[3:1];
        end
    end

    // reserved bits are stored as written; the host keeps them zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pace_cfg_r <= `MCR_RST_PACE;
        end else if (reg_wr && reg_addr == `MCR_OFS_PACE) begin
            pace_cfg_r <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chan_dis_r <= `MCR_RST_CHAN_DIS;
        end else if (reg_wr && reg_addr == `MCR_OFS_CHAN_DIS) begin
            chan_dis_r <= reg_wdata;
        end
    end

    // ---------------- read path ----------------
    always_comb begin
        temp_low_view = 4'h0;
        if (temp_on) begin
            if (os_ctl_r[`MCR_TEMP_RES_BIT]) begin
                temp_low_view = temp_low_result;
            end else begin
                // only the result lsb is meaningful here; the rest read zero
                temp_low_view = {temp_low_result[3], 3'h0};
            end
        end
    end

    assign os_status = (pin_mode == MCR_PIN_OVERTEMP) ? pin_level_r : 1'b1;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `MCR_OFS_FAN_PIN:  rdata_r <= fan_cfg_r;
                `MCR_OFS_OS_RES:   rdata_r <= {temp_low_view, os_ctl_r, os_status};
                `MCR_OFS_PACE:     rdata_r <= pace_cfg_r;
                `MCR_OFS_CHAN_DIS: rdata_r <= chan_dis_r;
                default:           rdata_r <= 8'h00;
            endcase
        end
    end

    // ---------------- fan configuration ----------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level_mode_r <= 2'h0;
            act_low_r    <= 2'h0;
            div1_r       <= 2'h0;
            div2_r       <= 2'h0;
        end else begin
            level_mode_r <= {fan_cfg_r[`MCR_SECOND_TACH_INPUT_LEVEL_BIT],
                             fan_cfg_r[`MCR_FIRST_TACH_INPUT_LEVEL_BIT]};
            act_low_r[0] <= fan_cfg_r[`MCR_FIRST_TACH_INPUT_LEVEL_BIT] &&
                            fan_cfg_r[`MCR_FIRST_TACH_INPUT_FIELD_LO +: 2] == `MCR_FIELD_ACT_LOW;
            act_low_r[1] <= fan_cfg_r[`MCR_SECOND_TACH_INPUT_LEVEL_BIT] &&
                            fan_cfg_r[`MCR_SECOND_TACH_INPUT_FIELD_LO +: 2] == `MCR_FIELD_ACT_LOW;
            div1_r <= div_of(fan_cfg_r[`MCR_FIRST_TACH_INPUT_LEVEL_BIT],
                             fan_cfg_r[`MCR_FIRST_TACH_INPUT_FIELD_LO +: 2]);
            div2_r <= div_of(fan_cfg_r[`MCR_SECOND_TACH_INPUT_LEVEL_BIT],
                             fan_cfg_r[`MCR_SECOND_TACH_INPUT_FIELD_LO +: 2]);
        end
    end

    // ---------------- shared pin sense ----------------
    // a change is accepted only once the second and third stages agree
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_sync_r  <= {3{`MCR_RST_PIN_LEVEL}};
            pin_level_r <= `MCR_RST_PIN_LEVEL;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], shared_pin_i};
            if (pin_sync_r[1] == pin_sync_r[2]) begin
                pin_level_r <= pin_sync_r[2];
            end
        end
    end

    // ---------------- overtemp event ----------------
    // one-shot: a new crossing beats a service in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            over_q_r <= 1'b0;
            os_hit_r <= 1'b0;
        end else begin
            over_q_r <= temp_over_limit;
            if (!os_ctl_r[`MCR_OS_ONESHOT_BIT] || !temp_on) begin
                os_hit_r <= 1'b0;
            end else if (temp_over_limit && !over_q_r) begin
                os_hit_r <= 1'b1;
            end else if (os_service) begin
                os_hit_r <= 1'b0;
            end
        end
    end

    assign os_assert = os_ctl_r[`MCR_OS_ONESHOT_BIT] ? os_hit_r
                                                      : temp_over_limit && temp_on;

    // ---------------- reset pulse ----------------
    // the request is only acted on in reset mode; elsewhere it waits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rst_busy_r <= 1'b0;
            rst_cnt_r  <= 32'h0;
            rst_done_r <= 1'b0;
        end else begin
            rst_done_r <= 1'b0;
            if (rst_busy_r) begin
                if (rst_cnt_r == 32'(RST_PULSE_CYC - 1)) begin
                    rst_busy_r <= 1'b0;
                    rst_done_r <= 1'b1;
                end else begin
                    rst_cnt_r <= rst_cnt_r + 32'h1;
                end
            end else if (reset_request && !rst_done_r && pin_mode == MCR_PIN_RESET) begin
                rst_busy_r <= 1'b1;
                rst_cnt_r  <= 32'h0;
            end
        end
    end

    // ---------------- shared pin drive ----------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_o_r  <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            case (pin_mode)
                MCR_PIN_OVERTEMP: begin
                    pin_oe_r <= 1'b1;
                    pin_o_r  <= os_assert ? os_ctl_r[`MCR_OS_POL_BIT]
                                          : ~os_ctl_r[`MCR_OS_POL_BIT];
                end
                MCR_PIN_RESET: begin
                    pin_oe_r <= rst_busy_r;
                    pin_o_r  <= 1'b0;
                end
                default: begin
                    pin_oe_r <= 1'b0;
                    pin_o_r  <= 1'b0;
                end
            endcase
        end
    end

    // ---------------- channel disable ----------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            limit_evt_r <= 8'h00;
            reading_r   <= 12'h000;
        end else begin
            limit_evt_r <= raw_limit_evt & ~chan_dis_r;
            reading_r   <= chan_dis_r[reading_chan] ? 12'h000 : reading_in;
        end
    end

    mcr_pacer #(
        .UNIT_CYC (PACE_UNIT_CYC)
    ) u_pacer (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .continuous  (pace_cfg_r[`MCR_CONT_BIT]),
        .rate_count  (conv_rate_count),
        .cycle_done  (cycle_done),
        .cycle_start (cycle_start)
    );

    assign reg_rdata          = rdata_r;
    assign fan_level_mode     = level_mode_r;
    assign fan_active_low     = act_low_r;
    assign first_tach_input_div_shift     = div1_r;
    assign second_tach_input_div_shift     = div2_r;
    assign shared_pin_o       = pin_o_r;
    assign shared_pin_oe      = pin_oe_r;
    assign reset_request_done = rst_done_r;
    assign chan_skip          = chan_dis_r;
    assign limit_evt          = limit_evt_r;
    assign reading_out        = reading_r;

    // helper: length of the reset pulse, for the checks only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hlp_rst_len <= 32'h0;
        end else begin
            hlp_rst_len <= rst_busy_r ? hlp_rst_len + 32'h1 : 32'h0;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_fan_level_mode: assert property (
        1'b1 |=> fan_level_mode == $past(fan_cfg_r[1:0]))
        else $error("fan level mode does not follow its bits");

    a_second_tach_input_divisor: assert property (
        (!$past(rst) && !fan_cfg_r[`MCR_SECOND_TACH_INPUT_LEVEL_BIT]) // edge leaving reset loads reset values
        |=> second_tach_input_div_shift == $past(fan_cfg_r[5:4]))
        else $error("second fan divisor does not follow its field");

    a_first_tach_input_act_low: assert property (
        (fan_cfg_r[`MCR_FIRST_TACH_INPUT_LEVEL_BIT] && fan_cfg_r[3:2] == 2'h1)
        |=> fan_active_low[0] && first_tach_input_div_shift == 2'h0)
        else $error("first fan level input not active low");

    a_os_pin_level: assert property (
        (fan_cfg_r[7:6] == 2'b01 && os_assert)
        |=> shared_pin_oe && shared_pin_o == $past(os_ctl_r[`MCR_OS_POL_BIT]))
        else $error("overtemp pin not driven at its active level");

    a_pin_disabled: assert property (
        (fan_cfg_r[7:6] == 2'b11) |=> !shared_pin_oe)
        else $error("shared pin driven while disabled");

    a_rst_pulse_low: assert property (
        (rst_busy_r && fan_cfg_r[7:6] == 2'b10) |=> shared_pin_oe && !shared_pin_o)
        else $error("reset pulse not driven low on the shared pin");

    a_rst_pulse_len: assert property (
        $fell(rst_busy_r) |-> hlp_rst_len == RST_PULSE_CYC && reset_request_done)
        else $error("reset pulse length wrong or request not cleared");

    a_os_status_mirror: assert property (
        (reg_rd && reg_addr == `MCR_OFS_OS_RES && pin_mode == MCR_PIN_OVERTEMP)
        |=> reg_rdata[0] == $past(pin_level_r))
        else $error("overtemp status bit does not mirror the pin");

    a_os_oneshot_hold: assert property (
        (os_ctl_r[`MCR_OS_ONESHOT_BIT] && temp_on && os_hit_r && !os_service)
        ##1 (os_ctl_r[`MCR_OS_ONESHOT_BIT] && temp_on) |-> os_hit_r)
        else $error("one-shot overtemp released before service");

    a_chan_muted: assert property (
        1'b1 |=> (limit_evt & $past(chan_dis_r)) == 8'h00)
        else $error("disabled channel still raised a limit event");

    a_temp_read_zero: assert property (
        (reading_chan == 3'h7 && chan_dis_r[`MCR_TEMP_CHAN]) |=> reading_out == 12'h000)
        else $error("disabled temperature reading not zero");

endmodule

// ==== bench/mcr_host_model.sv ====
// Purpose: host model: reset request bit and conversion sequencer
// Assumes: the bank pulses reset_request_done to clear the request
// Notes:   sequencer reports done six cycles after each start
module mcr_host_model (
    input  wire logic ref_clk,            // clock
    input  wire logic rst,                // reset
    input  wire logic req_set,            // bench sets request
    input  wire logic reset_request_done, // clear pulse
    input  wire logic cycle_start,        // cycle begins
    output logic      reset_request,      // request bit
    output logic      cycle_done          // cycle ends
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) reset_request <= 1'b0;
        else if (reset_request_done) reset_request <= 1'b0;
        else if (req_set) reset_request <= 1'b1;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) cnt <= 3'h0;
        else cnt <= cycle_start ? 3'h6 : cnt - 3'(cnt != 3'h0);
    end
    assign cycle_done = (cnt == 3'h1);
endmodule

// ==== bench/mcr_config_regs_tb.sv ====
// Purpose: self-checking bench of the configuration bank
// Assumes: short pace unit and pulse counts keep the run brief
// Notes:   shared pin pulled up when released
module mcr_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req_set = 1'b0;
    logic        temp_over_limit = 1'b0, os_service = 1'b0, cycle_done, cycle_start;
    logic [7:0]  reg_addr = 8'h0, reg_wdata = 8'h0, conv_rate_count = 8'h0;
    logic [7:0]  raw_limit_evt = 8'hff, reg_rdata, chan_skip, limit_evt;
    logic [3:0]  temp_low_result = 4'ha;
    logic [2:0]  reading_chan = 3'h0;
    logic [11:0] reading_in = 12'habc, reading_out;
    logic [1:0]  fan_level_mode, fan_active_low, first_tach_input_div_shift, second_tach_input_div_shift;
    logic        shared_pin_o, shared_pin_oe, reset_request, reset_request_done;
    wire logic   shared_pin_i = shared_pin_oe ? shared_pin_o : 1'b1;
    int          error_cnt = 0, n_compared = 0, n, c, g;
    always #5 ref_clk = ~ref_clk;
    mcr_config_regs #(.PACE_UNIT_CYC(10), .RST_PULSE_CYC(5)) dut (.ref_clk, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fan_level_mode, .fan_active_low,
        .first_tach_input_div_shift, .second_tach_input_div_shift, .shared_pin_i, .shared_pin_o, .shared_pin_oe,
        .temp_over_limit, .os_service, .reset_request, .reset_request_done, .temp_low_result,
        .cycle_done, .conv_rate_count, .cycle_start, .chan_skip, .raw_limit_evt, .limit_evt,
        .reading_chan, .reading_in, .reading_out);
    mcr_host_model host (.ref_clk, .rst, .req_set, .reset_request_done, .cycle_start,
        .reset_request, .cycle_done);
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, e);
    endtask
    task automatic pin(input logic [1:0] e);
        repeat (8) @(negedge ref_clk);
        chk({shared_pin_oe, shared_pin_o & shared_pin_oe}, e);
    endtask
    // counts cycles up to the next cycle start
    task automatic gap(output int k);
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (cycle_start !== 1'b1 && k < 400);
        if (k >= 400) begin
            error_cnt++;
            wrap_up();
        end
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h05, 8'h14);
        rd(8'h07, 8'h40);
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h00);
        rd(8'h06, 8'h81);
        $display("test reset values end");
        wr(8'h05, 8'h2c);
        chk({fan_level_mode, first_tach_input_div_shift, second_tach_input_div_shift}, 6'h0e);
        wr(8'h05, 8'h07);
        chk({fan_level_mode, fan_active_low, first_tach_input_div_shift, second_tach_input_div_shift}, 8'hd0);
        $display("test fan end");
        wr(8'h05, 8'h40);
        wr(8'h06, 8'h02);
        @(posedge ref_clk) temp_over_limit <= 1'b1;
        pin(2'b11);
        rd(8'h06, 8'h83);
        @(posedge ref_clk) temp_over_limit <= 1'b0;
        pin(2'b10);
        rd(8'h06, 8'h82);
        wr(8'h06, 8'h06);
        @(posedge ref_clk) temp_over_limit <= 1'b1;
        @(posedge ref_clk) temp_over_limit <= 1'b0;
        pin(2'b11);
        @(posedge ref_clk) os_service <= 1'b1;
        @(posedge ref_clk) os_service <= 1'b0;
        pin(2'b10);
        wr(8'h06, 8'h00);
        pin(2'b11);
        $display("test overtemp end");
        wr(8'h05, 8'hc0);
        @(posedge ref_clk) req_set <= 1'b1;
        @(posedge ref_clk) req_set <= 1'b0;
        pin(2'b00);
        chk(reset_request, 1'b1);
        wr(8'h05, 8'h80);
        @(negedge ref_clk);
        chk({shared_pin_oe, shared_pin_o}, 2'b10);
        pin(2'b00);
        chk(reset_request, 1'b0);
        $display("test reset pulse end");
        wr(8'h08, 8'h81);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk) reading_chan <= 3'(i);
            repeat (2) @(negedge ref_clk);
            chk(reading_out, (i % 7 == 0) ? 16'h0 : 16'habc);
        end
        chk({chan_skip, limit_evt}, 16'h817e);
        rd(8'h06, 8'h01);
        wr(8'h08, 8'h00);
        wr(8'h06, 8'h08);
        rd(8'h06, 8'ha9);
        $display("test channels end");
        @(posedge ref_clk) conv_rate_count <= 8'hff;
        wr(8'h07, 8'h01);
        gap(n);
        gap(c);
        @(posedge ref_clk) conv_rate_count <= 8'h01;
        wr(8'h07, 8'h00);
        gap(n);
        gap(g);
        chk({c < 20, g - c >= 139 && g - c <= 142}, 2'b11);
        $display("test pacing end");
        wrap_up();
    end
endmodule
